//--- include/ccl_pkg.sv
// Constants and types shared by the control input configuration logic
package ccl_pkg;

  // Widths
  localparam int unsigned CCL_AW       = 8;
  localparam int unsigned CCL_DW       = 32;
  localparam int unsigned CCL_NCTL     = 8;
  localparam int unsigned CCL_NHEAVY   = 4;
  localparam int unsigned CCL_NGRP     = 6;
  localparam int unsigned CCL_NROUTE   = 6;
  localparam int unsigned CCL_SYNC_W   = 10;

  // Register byte offsets
  localparam logic [7:0] CCL_OFF_LAMP_SEL  = 8'h00;
  localparam logic [7:0] CCL_OFF_POL_SEL   = 8'h04;
  localparam logic [7:0] CCL_OFF_STAB_SEL  = 8'h08;
  localparam logic [7:0] CCL_OFF_INST_SEL  = 8'h0c;
  localparam logic [7:0] CCL_OFF_BANK_SEL  = 8'h10;
  localparam logic [7:0] CCL_OFF_IND_SEL   = 8'h14;
  localparam logic [7:0] CCL_OFF_LATCH_SEL = 8'h18;
  localparam logic [7:0] CCL_OFF_FULL_SEL  = 8'h1c;
  localparam logic [7:0] CCL_OFF_ROUTE0    = 8'h20;
  localparam logic [7:0] CCL_OFF_ROUTE_STEP = 8'h04;
  localparam logic [7:0] CCL_OFF_CMD       = 8'h38;
  localparam logic [7:0] CCL_OFF_STATUS    = 8'h3c;

  // Reset values
  localparam logic [7:0] CCL_RST_LAMP_SEL  = 8'h03;
  localparam logic [7:0] CCL_RST_POL_SEL   = 8'h00;
  localparam logic [7:0] CCL_RST_GRP_SEL   = 8'h00;
  localparam logic [7:0] CCL_RST_ROUTE     = 8'h00;

  // Field positions
  localparam int unsigned CCL_CMD_MAIN_BIT   = 0;
  localparam int unsigned CCL_CMD_SECOND_BIT = 1;
  localparam int unsigned CCL_ST_BANK_BIT    = 0;
  localparam int unsigned CCL_ST_STAB_BIT    = 1;
  localparam int unsigned CCL_ST_INST_BIT    = 2;
  localparam int unsigned CCL_ST_LAMP_BIT    = 3;
  localparam int unsigned CCL_ST_CTL_LSB     = 8;

  // Function group index within the selector matrix
  localparam int unsigned CCL_G_STAB  = 0;
  localparam int unsigned CCL_G_INST  = 1;
  localparam int unsigned CCL_G_BANK  = 2;
  localparam int unsigned CCL_G_IND   = 3;
  localparam int unsigned CCL_G_LATCH = 4;
  localparam int unsigned CCL_G_FULL  = 5;

  // Bus phase tracking
  typedef enum logic [1:0] {
    CCL_ST_IDLE = 2'b01,
    CCL_ST_ACK  = 2'b10
  } ccl_apb_st_t;

endpackage : ccl_pkg

//--- logic/ccl_in_sync.sv
// Three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/10ps
module ccl_in_sync
  import ccl_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  arst_n,
  // Raw and filtered levels
  input  wire logic [CCL_SYNC_W-1:0] din,
  output logic      [CCL_SYNC_W-1:0] dout
);

  typedef struct packed {
    logic [CCL_SYNC_W-1:0] s1;
    logic [CCL_SYNC_W-1:0] s2;
    logic [CCL_SYNC_W-1:0] s3;
    logic [CCL_SYNC_W-1:0] lvl;
  } ccl_sync_t;

  ccl_sync_t q;
  ccl_sync_t d;

  always_comb begin
    d    = q;
    d.s1 = din;
    d.s2 = q.s1;
    d.s3 = q.s2;
    // Level moves only where stages two and three agree
    d.lvl = (q.s2 & q.s3) | (q.lvl & (q.s2 | q.s3));
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign dout = q.lvl;

endmodule : ccl_in_sync

//--- logic/ccl_sel_matrix.sv
// Selector matrix: each group ORs the sources its mask bits pick
`timescale 1ns/10ps
module ccl_sel_matrix
  import ccl_pkg::*;
(
  // Masks, one byte per group
  input  wire logic [CCL_NGRP-1:0][CCL_NCTL-1:0] sel,
  // Source levels
  input  wire logic [CCL_NCTL-1:0]               src,
  // Group results
  output logic      [CCL_NGRP-1:0]               hit
);

  genvar g;
  generate
    for (g = 0; g < CCL_NGRP; g++) begin : g_grp
      assign hit[g] = |(sel[g] & src);
    end
  endgenerate

endmodule : ccl_sel_matrix

//--- logic/ccl_ctl_cfg.sv
// Control input configuration, fault lamp and intermodular routing
`timescale 1ns/10ps
module ccl_ctl_cfg
  import ccl_pkg::*;
(
  // Clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    arst_n,
  // APB slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [CCL_AW-1:0]       paddr,
  input  wire logic [CCL_DW-1:0]       pwdata,
  output logic      [CCL_DW-1:0]       prdata,
  output logic                         pready,
  output logic                         pslverr,
  // Station control pins
  input  wire logic [4:0]              ext_ctl_in,
  input  wire logic [2:0]              intermod_block_in,
  input  wire logic                    pb_main_bank,
  input  wire logic                    pb_second_bank,
  // Protection stage signals, same clock
  input  wire logic [CCL_NHEAVY-1:0]   heavy_out,
  input  wire logic [1:0]              diff_op_on_heavy,
  input  wire logic [2:0]              stage_sig,
  // Lamp and stage control
  output logic                         fault_lamp,
  output logic                         stab_stage_block,
  output logic                         inst_stage_block,
  output logic                         bank_second_active,
  // Reset pulses
  output logic                         indicator_clear,
  output logic                         latch_release,
  output logic                         record_clear,
  // Intermodular outputs
  output logic      [2:0]              intermod_event_lines,
  output logic      [2:0]              intermod_block_out
);

  typedef struct packed {
    ccl_apb_st_t                          st;
    logic                                 pready;
    logic                                 pslverr;
    logic [CCL_DW-1:0]                    prdata;
    logic [CCL_NCTL-1:0]                  lamp_sel;
    logic [CCL_NCTL-1:0]                  pol_sel;
    logic [CCL_NGRP-1:0][CCL_NCTL-1:0]    grp_sel;
    logic [CCL_NROUTE-1:0][CCL_NCTL-1:0]  route_sel;
    logic [1:0]                           pb_prev;
    logic [2:0]                           rst_prev;
    logic                                 fault_lamp;
    logic                                 stab_block;
    logic                                 inst_block;
    logic                                 bank_second;
    logic                                 ind_clr;
    logic                                 latch_rel;
    logic                                 rec_clr;
    logic [2:0]                           ev_out;
    logic [2:0]                           blk_out;
  } ccl_state_t;

  localparam ccl_state_t CCL_STATE_RST = '{
    st:         CCL_ST_IDLE,
    pready:     1'b0,
    pslverr:    1'b0,
    prdata:     '0,
    lamp_sel:   CCL_RST_LAMP_SEL,
    pol_sel:    CCL_RST_POL_SEL,
    grp_sel:    {CCL_NGRP{CCL_RST_GRP_SEL}},
    route_sel:  {CCL_NROUTE{CCL_RST_ROUTE}},
    pb_prev:    2'h0,
    rst_prev:   3'h0,
    fault_lamp: 1'b0,
    stab_block: 1'b0,
    inst_block: 1'b0,
    bank_second: 1'b0,
    ind_clr:    1'b0,
    latch_rel:  1'b0,
    rec_clr:    1'b0,
    ev_out:     3'h0,
    blk_out:    3'h0
  };

  ccl_state_t q;
  ccl_state_t d;

  logic [CCL_SYNC_W-1:0] pin_raw;
  logic [CCL_SYNC_W-1:0] pin_lvl;
  logic [CCL_NCTL-1:0]   ctl_act;
  logic [CCL_NCTL-1:0]   route_src;
  logic [CCL_NGRP-1:0]   grp_hit;
  logic [CCL_NROUTE-1:0] route_hit;

  // Pin inputs through the synchroniser
  assign pin_raw = {pb_second_bank, pb_main_bank,
                    intermod_block_in, ext_ctl_in};

  ccl_in_sync u_sync (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .din     (pin_raw),
    .dout    (pin_lvl)
  );

  // Active state per control signal
  assign ctl_act = pin_lvl[CCL_NCTL-1:0] ^ q.pol_sel;

  // Function groups on the control signals
  ccl_sel_matrix u_func (
    .sel (q.grp_sel),
    .src (ctl_act),
    .hit (grp_hit)
  );

  // Routing sources: stage signals low, external inputs above
  assign route_src = {ctl_act[4:0], stage_sig};

  ccl_sel_matrix u_route (
    .sel (q.route_sel),
    .src (route_src),
    .hit (route_hit)
  );

  // Register decode and read mux
  logic                 addr_hit;
  logic [CCL_DW-1:0]    rd_val;
  logic [CCL_NCTL-1:0]  wr_byte;
  logic                 wr_now;
  logic                 cmd_main;
  logic                 cmd_second;
  logic [1:0]           pb_rise;
  logic [2:0]           rst_lvl;
  logic [2:0]           rst_rise;
  logic                 bank_lock;
  logic                 lamp_evt;
  logic                 ind_clr_now;

  always_comb begin
    addr_hit = 1'b1;
    rd_val   = '0;
    case (paddr)
      CCL_OFF_LAMP_SEL:  rd_val[CCL_NCTL-1:0] = q.lamp_sel;
      CCL_OFF_POL_SEL:   rd_val[CCL_NCTL-1:0] = q.pol_sel;
      CCL_OFF_STAB_SEL:  rd_val[CCL_NCTL-1:0] = q.grp_sel[CCL_G_STAB];
      CCL_OFF_INST_SEL:  rd_val[CCL_NCTL-1:0] = q.grp_sel[CCL_G_INST];
      CCL_OFF_BANK_SEL:  rd_val[CCL_NCTL-1:0] = q.grp_sel[CCL_G_BANK];
      CCL_OFF_IND_SEL:   rd_val[CCL_NCTL-1:0] = q.grp_sel[CCL_G_IND];
      CCL_OFF_LATCH_SEL: rd_val[CCL_NCTL-1:0] = q.grp_sel[CCL_G_LATCH];
      CCL_OFF_FULL_SEL:  rd_val[CCL_NCTL-1:0] = q.grp_sel[CCL_G_FULL];
      CCL_OFF_CMD:       rd_val = '0;
      CCL_OFF_STATUS: begin
        rd_val[CCL_ST_BANK_BIT] = q.bank_second;
        rd_val[CCL_ST_STAB_BIT] = q.stab_block;
        rd_val[CCL_ST_INST_BIT] = q.inst_block;
        rd_val[CCL_ST_LAMP_BIT] = q.fault_lamp;
        rd_val[CCL_ST_CTL_LSB +: CCL_NCTL] = ctl_act;
      end
      default: begin
        addr_hit = 1'b0;
        for (int i = 0; i < CCL_NROUTE; i++) begin
          if (paddr == CCL_OFF_ROUTE0 + 8'(i) * CCL_OFF_ROUTE_STEP) begin
            addr_hit = 1'b1;
            rd_val[CCL_NCTL-1:0] = q.route_sel[i];
          end
        end
      end
    endcase
  end

  // Write strobe: the edge where the master sees pready high
  assign wr_now  = (q.st == CCL_ST_ACK) & psel & penable & pwrite;
  assign wr_byte = pwdata[CCL_NCTL-1:0];

  // Bank commands from bus and push-buttons
  assign pb_rise    = pin_lvl[CCL_SYNC_W-1:CCL_NCTL] & ~q.pb_prev;
  assign cmd_main   = pb_rise[0] |
                      (wr_now & (paddr == CCL_OFF_CMD) &
                       pwdata[CCL_CMD_MAIN_BIT]);
  assign cmd_second = pb_rise[1] |
                      (wr_now & (paddr == CCL_OFF_CMD) &
                       pwdata[CCL_CMD_SECOND_BIT]);

  // Reset functions on activation edges
  assign rst_lvl  = {grp_hit[CCL_G_FULL], grp_hit[CCL_G_LATCH],
                     grp_hit[CCL_G_IND]};
  assign rst_rise = rst_lvl & ~q.rst_prev;
  assign ind_clr_now = |rst_rise;

  // Lamp events: selected heavy outputs and differential operate
  assign lamp_evt = |(heavy_out & q.lamp_sel[CCL_NHEAVY-1:0])
                  | (|diff_op_on_heavy);

  assign bank_lock = |q.grp_sel[CCL_G_BANK];

  always_comb begin
    d = q;

    // Bus handshake: one wait state, answer registered
    case (q.st)
      CCL_ST_IDLE: begin
        d.pready  = 1'b0;
        d.pslverr = 1'b0;
        if (psel & penable) begin
          d.st      = CCL_ST_ACK;
          d.pready  = 1'b1;
          d.pslverr = ~addr_hit;
          d.prdata  = pwrite ? '0 : rd_val;
        end
      end
      CCL_ST_ACK: begin
        d.st      = CCL_ST_IDLE;
        d.pready  = 1'b0;
        d.pslverr = 1'b0;
        d.prdata  = '0;
      end
      default: begin
        d.st      = CCL_ST_IDLE;
        d.pready  = 1'b0;
        d.pslverr = 1'b0;
      end
    endcase

    // Register writes
    if (wr_now) begin
      case (paddr)
        CCL_OFF_LAMP_SEL:  d.lamp_sel = wr_byte;
        CCL_OFF_POL_SEL:   d.pol_sel = wr_byte;
        CCL_OFF_STAB_SEL:  d.grp_sel[CCL_G_STAB] = wr_byte;
        CCL_OFF_INST_SEL:  d.grp_sel[CCL_G_INST] = wr_byte;
        CCL_OFF_BANK_SEL:  d.grp_sel[CCL_G_BANK] = wr_byte;
        CCL_OFF_IND_SEL:   d.grp_sel[CCL_G_IND] = wr_byte;
        CCL_OFF_LATCH_SEL: d.grp_sel[CCL_G_LATCH] = wr_byte;
        CCL_OFF_FULL_SEL:  d.grp_sel[CCL_G_FULL] = wr_byte;
        default: begin
          for (int i = 0; i < CCL_NROUTE; i++) begin
            if (paddr == CCL_OFF_ROUTE0 + 8'(i) * CCL_OFF_ROUTE_STEP) begin
              d.route_sel[i] = wr_byte;
            end
          end
        end
      endcase
    end

    // Stage blocking
    d.stab_block = grp_hit[CCL_G_STAB];
    d.inst_block = grp_hit[CCL_G_INST];

    // Setting bank selection
    if (bank_lock) begin
      d.bank_second = ~grp_hit[CCL_G_BANK];
    end else if (cmd_second) begin
      d.bank_second = 1'b1;
    end else if (cmd_main) begin
      d.bank_second = 1'b0;
    end
    d.pb_prev = pin_lvl[CCL_SYNC_W-1:CCL_NCTL];

    // Reset pulses
    d.rst_prev  = rst_lvl;
    d.ind_clr   = ind_clr_now;
    d.latch_rel = rst_rise[1] | rst_rise[2];
    d.rec_clr   = rst_rise[2];

    // Fault lamp holds until cleared; a new event wins over the clear
    d.fault_lamp = lamp_evt | (q.fault_lamp & ~ind_clr_now);

    // Intermodular routing outputs
    d.ev_out  = route_hit[2:0];
    d.blk_out = route_hit[5:3];
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      q <= CCL_STATE_RST;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign prdata               = q.prdata;
  assign pready               = q.pready;
  assign pslverr              = q.pslverr;
  assign fault_lamp           = q.fault_lamp;
  assign stab_stage_block     = q.stab_block;
  assign inst_stage_block     = q.inst_block;
  assign bank_second_active   = q.bank_second;
  assign indicator_clear      = q.ind_clr;
  assign latch_release        = q.latch_rel;
  assign record_clear         = q.rec_clr;
  assign intermod_event_lines = q.ev_out;
  assign intermod_block_out   = q.blk_out;

endmodule : ccl_ctl_cfg

//--- tb/ccl_ctl_cfg_properties.sv
// Port checks for the control input configuration block
`timescale 1ns/10ps
module ccl_ctl_cfg_props
  import ccl_pkg::*;
(
  // Clock and reset
  input wire logic              clk_sys,
  input wire logic              arst_n,
  // APB
  input wire logic              psel,
  input wire logic              penable,
  input wire logic [CCL_DW-1:0] prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // Lamp and reset pulses
  input wire logic [1:0]        diff_op_on_heavy,
  input wire logic              fault_lamp,
  input wire logic              indicator_clear,
  input wire logic              latch_release,
  input wire logic              record_clear
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  sequence s_access;
    psel && penable && !pready;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  apb_answer_a: assert property (s_access |=> s_answer)
    else $error("access phase not answered after one cycle");
  ack_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  rdata_idle_a: assert property (!pready |-> prdata == '0)
    else $error("read data not zero outside answer");
  err_ack_a: assert property (pslverr |-> pready)
    else $error("error flag without pready");
  diff_lamp_a: assert property (|diff_op_on_heavy |=> fault_lamp)
    else $error("differential operate did not light lamp");
  ind_pulse_a: assert property (indicator_clear |=> !indicator_clear)
    else $error("indicator clear held over one cycle");
  latch_ind_a: assert property (latch_release |-> indicator_clear)
    else $error("latch release without indicator clear");
  full_all_a: assert property (record_clear |->
    latch_release && indicator_clear)
    else $error("record clear without other resets");
endmodule : ccl_ctl_cfg_props

bind ccl_ctl_cfg ccl_ctl_cfg_props u_props (
  .clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .diff_op_on_heavy(diff_op_on_heavy), .fault_lamp(fault_lamp),
  .indicator_clear(indicator_clear), .latch_release(latch_release),
  .record_clear(record_clear)
);

//--- tb/ccl_stn_model.sv
// Station wiring and push-button model
`timescale 1ns/10ps
module ccl_stn_model (
  // Clock
  input  wire logic       clk_sys,
  // Requested levels, set bit means voltage applied
  input  wire logic [7:0] lvl_req,
  input  wire logic [1:0] pb_req,
  // Pins toward the block
  output logic      [4:0] ext_ctl_in,
  output logic      [2:0] intermod_block_in,
  output logic            pb_main_bank,
  output logic            pb_second_bank
);
  initial begin
    ext_ctl_in = 5'h00;
    intermod_block_in = 3'h0;
    pb_main_bank = 1'b0;
    pb_second_bank = 1'b0;
  end
  // Wiring changes land just after a clock edge
  always @(posedge clk_sys) begin
    {intermod_block_in, ext_ctl_in} <= lvl_req;
    {pb_second_bank, pb_main_bank} <= pb_req;
  end
endmodule : ccl_stn_model

//--- tb/ccl_tb.sv
// Self-checking bench for the control input configuration block
`timescale 1ns/10ps
module tb;
  import ccl_pkg::*;
  logic        clk_sys, arst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, lvl;
  logic [31:0] pwdata, prdata, rdv;
  logic [4:0]  ext_ctl_in;
  logic [3:0]  heavy_out;
  logic [2:0]  intermod_block_in, stage_sig, ev_l, blk_o;
  logic [1:0]  diff_op_on_heavy, pb;
  logic        pb_m, pb_s, lamp, stab, inst, bank, ind, lat, rec, rde;
  int          err_count = 0, num_checks = 0, n_ind, n_lat, n_rec;

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  ccl_ctl_cfg DUT (
    .clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_ctl_in(ext_ctl_in),
    .intermod_block_in(intermod_block_in), .pb_main_bank(pb_m),
    .pb_second_bank(pb_s), .heavy_out(heavy_out),
    .diff_op_on_heavy(diff_op_on_heavy), .stage_sig(stage_sig),
    .fault_lamp(lamp), .stab_stage_block(stab), .inst_stage_block(inst),
    .bank_second_active(bank), .indicator_clear(ind),
    .latch_release(lat), .record_clear(rec),
    .intermod_event_lines(ev_l), .intermod_block_out(blk_o));

  ccl_stn_model u_stn (
    .clk_sys(clk_sys), .lvl_req(lvl), .pb_req(pb),
    .ext_ctl_in(ext_ctl_in), .intermod_block_in(intermod_block_in),
    .pb_main_bank(pb_m), .pb_second_bank(pb_s));

  always @(posedge clk_sys) begin
    n_ind += (ind === 1'b1);
    n_lat += (lat === 1'b1);
    n_rec += (rec === 1'b1);
  end

  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : wt

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) err_count++;
    rdv = prdata;
    rde = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic pin(input logic [7:0] v);
    lvl <= v;
    wt(7);
  endtask : pin

  task automatic chk(input string nm, input logic [31:0] s,
                     input logic [31:0] x);
    num_checks++;
    if (s !== x) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, x, s);
    end
  endtask : chk

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results

  initial begin
    wt(20000);
    err_count++;
    results();
  end

  initial begin
    psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; lvl = 0;
    heavy_out = 0; diff_op_on_heavy = 0; stage_sig = 0; pb = 0; arst_n = 0;
    wt(3);
    arst_n <= 1'b1;
    wt(1);
    rd(CCL_OFF_LAMP_SEL); chk("lamp_sel", rdv, 32'h3);
    rd(CCL_OFF_POL_SEL); chk("polarity", rdv, 32'h0);
    rd(8'h40); chk("unmapped", {31'h0, rde}, 32'h1);
    $display("test registers done");
    wr(CCL_OFF_IND_SEL, 32'h01);
    for (int i = 0; i < 4; i++) begin
      wr(CCL_OFF_LAMP_SEL, 32'hf0); heavy_out <= 4'h1 << i; wt(3);
      chk("lamp upper", lamp, 1'b0);
      heavy_out <= 4'h0; wr(CCL_OFF_LAMP_SEL, 32'h1 << i);
      heavy_out <= 4'h1 << i; wt(3);
      chk("lamp on", lamp, 1'b1);
      heavy_out <= 4'h0; pin(8'h01); pin(8'h00);
      chk("lamp clear", lamp, 1'b0);
    end
    wr(CCL_OFF_LAMP_SEL, 32'h0);
    for (int j = 0; j < 2; j++) begin
      diff_op_on_heavy <= 2'h1 << j; wt(2);
      chk("lamp diff", lamp, 1'b1);
      diff_op_on_heavy <= 2'h0; pin(8'h01); pin(8'h00);
    end
    $display("test lamp done");
    for (int i = 0; i < 8; i++) begin
      wr(CCL_OFF_STAB_SEL, 32'h1 << i); wr(CCL_OFF_INST_SEL, 32'h1 << i);
      wr(CCL_OFF_POL_SEL, 32'h0); pin(8'h1 << i);
      chk("stab", stab, 1'b1);
      chk("inst", inst, 1'b1);
      rd(CCL_OFF_STATUS); chk("active", rdv[15:8], 8'h1 << i);
      wr(CCL_OFF_POL_SEL, 32'h1 << i); wt(3);
      chk("stab inv", stab, 1'b0);
      pin(8'h00); chk("inst inv", inst, 1'b1);
    end
    wr(CCL_OFF_STAB_SEL, 0); wr(CCL_OFF_INST_SEL, 0); wr(CCL_OFF_POL_SEL, 0);
    $display("test polarity done");
    pb <= 2'b10; wt(6); pb <= 2'b00; wt(6);
    chk("bank button", bank, 1'b1);
    wr(CCL_OFF_CMD, 32'h1); wt(2); chk("bank cmd", bank, 1'b0);
    wr(CCL_OFF_BANK_SEL, 32'h01);
    pin(8'h01); chk("bank main", bank, 1'b0);
    wr(CCL_OFF_CMD, 32'h2); pb <= 2'b10; wt(6); pb <= 2'b00; wt(6);
    chk("bank ignore", bank, 1'b0);
    pin(8'h00); chk("bank second", bank, 1'b1);
    wr(CCL_OFF_BANK_SEL, 0);
    $display("test bank done");
    wr(CCL_OFF_IND_SEL, 0);
    wr(CCL_OFF_LATCH_SEL, 32'h02); wr(CCL_OFF_FULL_SEL, 32'h04);
    n_ind = 0; n_lat = 0; n_rec = 0;
    pin(8'h02); wt(20); pin(8'h00);
    chk("latch", {n_ind[7:0], n_lat[7:0], n_rec[7:0]},
        24'h010100);
    n_ind = 0; n_lat = 0; n_rec = 0;
    pin(8'h04); wt(20); pin(8'h00);
    chk("full", {n_ind[7:0], n_lat[7:0], n_rec[7:0]},
        24'h010101);
    $display("test resets done");
    wr(CCL_OFF_ROUTE0, 32'h08); pin(8'h01);
    chk("event", ev_l, 3'b001);
    wr(CCL_OFF_ROUTE0 + 8'h0c, 32'h01); stage_sig <= 3'b001; wt(3);
    chk("block out", blk_o, 3'b001);
    $display("test routing done");
    results();
  end
endmodule : tb
